// [src/fan_tach_pkg.sv]
// constants, field layouts and carrier types for the fan clock and
// tachometer block; assumes a 250 MHz mclk and a 32-bit wishbone bus
package fan_tach_pkg;

    // -------------------------------------------------------------------
    // clocking
    // -------------------------------------------------------------------
    localparam int MCLK_HZ     = 250_000_000;  // mclk rate
    localparam int TACH_CLK_HZ = 1_000_000;    // internal count clock
    localparam int TACH_TICK_CYCLES = MCLK_HZ / TACH_CLK_HZ;

    // pwm step rates for each {source select, clock select} pair
    localparam int SPD_STEP_HZ_00 = 1_600_000;
    localparam int SPD_STEP_HZ_01 = 800_000;
    localparam int SPD_STEP_HZ_10 = 400_000;
    localparam int SPD_STEP_HZ_11 = 200_000;
    localparam logic [15:0] SPD_CYC_00 = 16'(MCLK_HZ / SPD_STEP_HZ_00);
    localparam logic [15:0] SPD_CYC_01 = 16'(MCLK_HZ / SPD_STEP_HZ_01);
    localparam logic [15:0] SPD_CYC_10 = 16'(MCLK_HZ / SPD_STEP_HZ_10);
    localparam logic [15:0] SPD_CYC_11 = 16'(MCLK_HZ / SPD_STEP_HZ_11);

    // -------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // -------------------------------------------------------------------
    localparam int          ADR_W       = 10;
    localparam logic [7:0]  IDX_FAN_A   = 8'h56;
    localparam logic [7:0]  IDX_FAN_B   = 8'h57;
    localparam logic [7:0]  IDX_CLK_CFG = 8'h58;
    localparam logic [7:0]  IDX_TACH_A  = 8'h59;
    localparam logic [7:0]  IDX_TACH_B  = 8'h5a;
    localparam logic [7:0]  IDX_PRE_A   = 8'h5b;
    localparam logic [7:0]  IDX_PRE_B   = 8'h5c;

    // -------------------------------------------------------------------
    // reset values (loaded on standby_power_on_reset)
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_CLK_CFG = 8'h50;
    localparam logic [7:0] RST_FAN     = 8'h00;
    localparam logic [7:0] RST_TACH    = 8'h00;
    localparam logic [7:0] RST_PRE     = 8'h00;

    // -------------------------------------------------------------------
    // field positions of fan_clock_config
    // -------------------------------------------------------------------
    localparam int CFG_SRC_A    = 0;
    localparam int CFG_SRC_B    = 1;
    localparam int CFG_MUL_A    = 2;
    localparam int CFG_MUL_B    = 3;
    localparam int CFG_DIV_A_LO = 4;
    localparam int CFG_DIV_B_LO = 6;

    // fan drive register: bit7 clock select, bits6:1 duty, bit0 force
    typedef struct packed {
        logic       clkSel;
        logic [5:0] duty;
        logic       forceHigh;
    } fan_reg_t;

    // what one tachometer meter needs from the registers
    typedef struct packed {
        logic [7:0] preload;
        logic [1:0] divSel;
    } tach_cfg_t;

endpackage

// [src/fan_tach_meter.sv]
// one fan tachometer period meter: counts prescaled internal clock
// ticks per tach pulse and latches the final count
// assumes tachPin is asynchronous to mclk; restart is a mclk pulse
`timescale 1ns/1ps
`default_nettype none
module fan_tach_meter #(
    parameter int TICK_CYCLES = fan_tach_pkg::TACH_TICK_CYCLES
) (
    input  wire logic                    mclk,    // 250 MHz clock
    input  wire logic                    rst,     // async, active high
    input  wire logic                    tachPin, // raw tach input
    input  wire fan_tach_pkg::tach_cfg_t cfg,     // preload and divisor
    input  wire logic                    restart, // preload was written
    output logic [7:0]                   result   // latched count
);
    import fan_tach_pkg::*;

    typedef enum logic [0:0] {
        WAIT_EDGE = 1'b0,
        MEASURE   = 1'b1
    } meter_state_t;

    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    logic         sync1_reg, sync2_reg, prev_reg;
    meter_state_t state_reg, state_next;
    logic [15:0]  base_reg, base_next;
    logic [2:0]   pre_reg, pre_next;
    logic [7:0]   count_reg, count_next;
    logic [7:0]   result_reg, result_next;
    logic         riseEdge, baseTick, divTick;
    logic [2:0]   divMask;

    // prescaler mask for divide by 1, 2, 4, 8
    always_comb
    begin
        unique case (cfg.divSel)
            2'b00: divMask = 3'h0;
            2'b01: divMask = 3'h1;
            2'b10: divMask = 3'h3;
            2'b11: divMask = 3'h7;
        endcase
    end

    assign riseEdge = sync2_reg & ~prev_reg;
    assign baseTick = (base_reg == 16'(TICK_CYCLES - 1));
    assign divTick  = baseTick && ((pre_reg & divMask) == divMask);

    // next values of the measurement
    always_comb
    begin
        state_next  = state_reg;
        base_next   = baseTick ? 16'h0000 : base_reg + 16'h0001;
        pre_next    = baseTick ? pre_reg + 3'h1 : pre_reg;
        count_next  = count_reg;
        result_next = result_reg;
        if (restart)
        begin
            state_next = WAIT_EDGE;
            count_next = cfg.preload;
            base_next  = 16'h0000;
            pre_next   = 3'h0;
        end
        else if (riseEdge)
        begin
            if (state_reg == MEASURE)
                result_next = count_reg;
            state_next = MEASURE;
            count_next = cfg.preload;
            base_next  = 16'h0000;
            pre_next   = 3'h0;
        end
        else if (state_reg == MEASURE && divTick && count_reg != 8'hff)
            count_next = count_reg + 8'h01;
    end

    // registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg  <= 1'b1;                          // tach idles high
            sync2_reg  <= 1'b1;                          // no false edge
            prev_reg   <= 1'b1;                          // after reset
            state_reg  <= WAIT_EDGE;
            base_reg   <= 16'h0000;
            pre_reg    <= 3'h0;
            count_reg  <= RST_PRE;
            result_reg <= RST_TACH;
        end
        else
        begin
            sync1_reg  <= tachPin;
            sync2_reg  <= sync1_reg;
            prev_reg   <= sync2_reg;
            state_reg  <= state_next;
            base_reg   <= base_next;
            pre_reg    <= pre_next;
            count_reg  <= count_next;
            result_reg <= result_next;
        end
    end

    assign result = result_reg;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    a_latch_on_edge: assert property (@(posedge mclk) disable iff (rst)
        riseEdge && !restart && state_reg == MEASURE
        |=> result_reg == $past(count_reg))
        else $error("final count not latched at pulse end");
    a_count_saturates: assert property (@(posedge mclk) disable iff (rst)
        state_reg == MEASURE && count_reg == 8'hff && !riseEdge && !restart
        |=> count_reg == 8'hff)
        else $error("tach count wrapped");
    a_preload_start: assert property (@(posedge mclk) disable iff (rst)
        restart |=> count_reg == $past(cfg.preload)
        && state_reg == WAIT_EDGE)
        else $error("count not loaded from preload");
    a_count_prescaled: assert property (@(posedge mclk) disable iff (rst)
        !divTick && !riseEdge && !restart
        |=> $stable(count_reg))
        else $error("count moved without prescaled tick");

endmodule // fan_tach_meter
`default_nettype wire

// [src/fan_clock_and_tach_count.sv]
// fan speed outputs and tachometer measurement with a wishbone slave
// assumes classic wishbone on mclk; tach inputs come from fan pins
`timescale 1ns/1ps
`default_nettype none
module fan_clock_and_tach_count #(
    parameter int TICK_CYCLES = fan_tach_pkg::TACH_TICK_CYCLES
) (
    input  wire logic                           mclk,       // 250 MHz
    input  wire logic                           rst,        // async reset
    input  wire logic                           cyc_i,      // bus cycle
    input  wire logic                           stb_i,      // strobe
    input  wire logic                           we_i,       // write
    input  wire logic [fan_tach_pkg::ADR_W-1:0] adr_i,      // byte address
    input  wire logic [3:0]                     sel_i,      // byte lanes
    input  wire logic [31:0]                    dat_i,      // write data
    output logic [31:0]                         dat_o,      // read data
    output logic                                ack_o,      // acknowledge
    input  wire logic                           fanTachA,   // tach pin a
    input  wire logic                           fanTachB,   // tach pin b
    output logic                                fanDriveA,  // fan_drive_a
    output logic                                fanDriveB   // fan_drive_b
);
    import fan_tach_pkg::*;

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------

    // mclk cycles per pwm step; doubling the speed halves the period
    function automatic logic [15:0] speedCycles(input logic src,
                                                input logic sel,
                                                input logic dbl);
        logic [15:0] c;
        unique case ({src, sel})
            2'b00: c = SPD_CYC_00;
            2'b01: c = SPD_CYC_01;
            2'b10: c = SPD_CYC_10;
            2'b11: c = SPD_CYC_11;
        endcase
        if (dbl)
            c = c >> 1;
        if (c == 16'h0000)
            c = 16'h0001;
        return c;
    endfunction

    // -------------------------------------------------------------------
    // registers and state
    // -------------------------------------------------------------------
    fan_reg_t    fan_reg [2];
    fan_reg_t    fan_next [2];
    logic [7:0]  cfg_reg, cfg_next;
    logic [7:0]  preA_reg, preA_next;
    logic [7:0]  preB_reg, preB_next;
    logic        ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic        rstA_reg, rstA_next;
    logic        rstB_reg, rstB_next;
    logic [15:0] spd_reg [2];
    logic [15:0] spd_next [2];
    logic [5:0]  pwm_reg [2];
    logic [5:0]  pwm_next [2];
    logic        drive_reg [2];
    logic        drive_next [2];
    logic [15:0] spdLim [2];
    logic [7:0]  tachA, tachB;
    logic [7:0]  idx;
    logic        req, wrEn;
    tach_cfg_t   tachCfgA, tachCfgB;

    assign idx  = adr_i[ADR_W-1:2];
    assign req  = cyc_i & stb_i;
    assign wrEn = req & ack_reg & we_i & sel_i[0];

    // -------------------------------------------------------------------
    // wishbone slave
    // -------------------------------------------------------------------

    // read data captured on the request edge, ack raised at that same edge
    always_comb
    begin
        ack_next = req & ~ack_reg;
        dat_next = dat_reg;
        if (req && !ack_reg)
        begin
            dat_next = 32'h0000_0000;
            unique case (idx)
                IDX_FAN_A:   dat_next[7:0] = fan_reg[0];
                IDX_FAN_B:   dat_next[7:0] = fan_reg[1];
                IDX_CLK_CFG: dat_next[7:0] = cfg_reg;
                IDX_TACH_A:  dat_next[7:0] = tachA;
                IDX_TACH_B:  dat_next[7:0] = tachB;
                IDX_PRE_A:   dat_next[7:0] = preA_reg;
                IDX_PRE_B:   dat_next[7:0] = preB_reg;
                default:     dat_next = 32'h0000_0000;
            endcase
        end
    end

    // register writes take effect at the acked edge; results are read only
    always_comb
    begin
        fan_next[0] = fan_reg[0];
        fan_next[1] = fan_reg[1];
        cfg_next    = cfg_reg;
        preA_next   = preA_reg;
        preB_next   = preB_reg;
        rstA_next   = 1'b0;
        rstB_next   = 1'b0;
        if (wrEn)
        begin
            unique case (idx)
                IDX_FAN_A:   fan_next[0] = dat_i[7:0];
                IDX_FAN_B:   fan_next[1] = dat_i[7:0];
                IDX_CLK_CFG: cfg_next    = dat_i[7:0];
                IDX_PRE_A:
                begin
                    preA_next = dat_i[7:0];
                    rstA_next = 1'b1;
                end
                IDX_PRE_B:
                begin
                    preB_next = dat_i[7:0];
                    rstB_next = 1'b1;
                end
                default:     cfg_next = cfg_reg;
            endcase
        end
    end

    // bus and register flops
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ack_reg    <= 1'b0;
            dat_reg    <= 32'h0000_0000;
            fan_reg[0] <= RST_FAN;
            fan_reg[1] <= RST_FAN;
            cfg_reg    <= RST_CLK_CFG;
            preA_reg   <= RST_PRE;
            preB_reg   <= RST_PRE;
            rstA_reg   <= 1'b0;
            rstB_reg   <= 1'b0;
        end
        else
        begin
            ack_reg    <= ack_next;
            dat_reg    <= dat_next;
            fan_reg[0] <= fan_next[0];
            fan_reg[1] <= fan_next[1];
            cfg_reg    <= cfg_next;
            preA_reg   <= preA_next;
            preB_reg   <= preB_next;
            rstA_reg   <= rstA_next;
            rstB_reg   <= rstB_next;
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // -------------------------------------------------------------------
    // fan speed clocks and drive outputs
    // -------------------------------------------------------------------

    // speed step period per fan
    assign spdLim[0] = speedCycles(cfg_reg[CFG_SRC_A], fan_reg[0].clkSel,
                                   cfg_reg[CFG_MUL_A]);
    assign spdLim[1] = speedCycles(cfg_reg[CFG_SRC_B], fan_reg[1].clkSel,
                                   cfg_reg[CFG_MUL_B]);

    // step divider, 64-step pwm counter and drive level
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            spd_next[i] = spd_reg[i] + 16'h0001;
            pwm_next[i] = pwm_reg[i];
            if (spd_reg[i] >= spdLim[i] - 16'h0001)
            begin
                spd_next[i] = 16'h0000;
                pwm_next[i] = pwm_reg[i] + 6'h01;
            end
            drive_next[i] = fan_reg[i].forceHigh
                          | (pwm_reg[i] < fan_reg[i].duty);
        end
    end

    // speed flops
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 2; i++)
            begin
                spd_reg[i]   <= 16'h0000;
                pwm_reg[i]   <= 6'h00;
                drive_reg[i] <= 1'b0;
            end
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                spd_reg[i]   <= spd_next[i];
                pwm_reg[i]   <= pwm_next[i];
                drive_reg[i] <= drive_next[i];
            end
        end
    end

    assign fanDriveA = drive_reg[0];
    assign fanDriveB = drive_reg[1];

    // -------------------------------------------------------------------
    // tachometer meters
    // -------------------------------------------------------------------
    assign tachCfgA = '{preload: preA_reg,
                        divSel: cfg_reg[CFG_DIV_A_LO+:2]};
    assign tachCfgB = '{preload: preB_reg,
                        divSel: cfg_reg[CFG_DIV_B_LO+:2]};

    // fan a meter
    fan_tach_meter #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_meter_a (
        .mclk    (mclk),
        .rst     (rst),
        .tachPin (fanTachA),
        .cfg     (tachCfgA),
        .restart (rstA_reg),
        .result  (tachA)
    );

    // fan b meter
    fan_tach_meter #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_meter_b (
        .mclk    (mclk),
        .rst     (rst),
        .tachPin (fanTachB),
        .cfg     (tachCfgB),
        .restart (rstB_reg),
        .result  (tachB)
    );

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    a_ack_one_cycle: assert property (@(posedge mclk) disable iff (rst)
        ack_o |=> !ack_o)
        else $error("ack held more than one cycle");
    a_ack_after_req: assert property (@(posedge mclk) disable iff (rst)
        req && !ack_o |=> ack_o)
        else $error("request not acknowledged next cycle");
    a_result_read_only: assert property (@(posedge mclk) disable iff (rst)
        wrEn && idx == IDX_TACH_A |=> $stable(cfg_reg)
        && $stable(preA_reg))
        else $error("write to result altered a register");
    a_force_high: assert property (@(posedge mclk) disable iff (rst)
        fan_reg[0].forceHigh |=> fanDriveA)
        else $error("forced fan drive not high");
    a_duty_zero_low: assert property (@(posedge mclk) disable iff (rst)
        !fan_reg[1].forceHigh && fan_reg[1].duty == 6'h00
        |=> !fanDriveB)
        else $error("zero duty fan drive not low");
    a_double_halves: assert property (@(posedge mclk) disable iff (rst)
        cfg_reg[CFG_MUL_A] && !cfg_reg[CFG_SRC_A] && !fan_reg[0].clkSel
        |-> spdLim[0] == (SPD_CYC_00 >> 1))
        else $error("multiplier did not double speed");

endmodule // fan_clock_and_tach_count
`default_nettype wire

// [dv/fan_model.sv]
// behavioural cooling fan: tach output pulled high when the rotor stops
// assumes halfPeriod in mclk cycles, zero meaning a stalled rotor
`timescale 1ns/1ps
`default_nettype none
module fan_model (
    input  wire logic        mclk,       // bench clock
    input  wire logic [15:0] halfPeriod, // tach half period, 0 stalls
    output logic             tach        // tach pin
);
    int cnt = 0;

    initial tach = 1'b1;

    // toggle tach each half period; idle high through the pull-up
    always @(posedge mclk)
    begin
        if (halfPeriod == 16'h0000)
        begin
            tach <= 1'b1;
            cnt <= 0;
        end
        else if (cnt >= int'(halfPeriod) - 1)
        begin
            tach <= ~tach;
            cnt <= 0;
        end
        else
            cnt <= cnt + 1;
    end
endmodule // fan_model
`default_nettype wire

// [dv/fan_clock_and_tach_count_test.sv]
// self-checking bench for the fan clock and tachometer block
// assumes two fan_model instances on the tach pins; TICK_CYCLES is 4
`timescale 1ns/1ps
`default_nettype none
module fan_clock_and_tach_count_test;
    import fan_tach_pkg::*;
    localparam int TICK = 4;
    localparam int HALF = 320;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] datW = 32'h0;
    logic [31:0] datR;
    logic        ack;
    logic        tachA;
    logic        tachB;
    logic        driveA;
    logic        driveB;
    logic        pickB = 1'b0;
    logic [15:0] halfA = 16'h0000;
    logic [15:0] halfB = 16'h0000;
    logic [7:0]  rd;
    int          errors = 0;
    int          comparisons = 0;
    int          span;
    wire logic   pickDrv = pickB ? driveB : driveA;

    // 250 MHz clock
    always #2 mclk = ~mclk;

    fan_clock_and_tach_count #(.TICK_CYCLES(TICK)) DUT (
        .mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
        .fanTachA(tachA), .fanTachB(tachB),
        .fanDriveA(driveA), .fanDriveB(driveB));
    fan_model fanA (.mclk(mclk), .halfPeriod(halfA), .tach(tachA));
    fan_model fanB (.mclk(mclk), .halfPeriod(halfB), .tach(tachB));

    // ----------------
    // shared tasks
    // ----------------
    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic fail(input string msg);
        errors++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp)
            fail($sformatf("%s got %h want %h", what, got, exp));
    endtask

    task automatic near(input logic [15:0] got, input int exp, input int tol,
                        input string what);
        comparisons++;
        if ($isunknown(got) || int'(got) > exp + tol || int'(got) + tol < exp)
            fail($sformatf("%s got %0d want %0d", what, got, exp));
    endtask

    // one classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h1;
        datW <= {24'h0, d};
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (ack !== 1'b1 && n < 64);
        rd = datR[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 64)
            fail("no acknowledge");
    endtask

    // waits for the chosen drive to reach a level, span counts cycles
    task automatic waitLevel(input logic v);
        span = 0;
        while (pickDrv !== v && span < 30000)
        begin
            @(posedge mclk);
            span++;
        end
        if (span >= 30000)
            fail("drive level never reached");
    endtask

    task automatic holdLevel(input logic v);
        int bad;
        bad = 0;
        repeat (8) @(posedge mclk);
        repeat (400)
        begin
            @(posedge mclk);
            if (pickDrv !== v)
                bad++;
        end
        comparisons++;
        if (bad != 0)
            fail("fan drive left its held level");
    endtask

    // ----------------
    // scenarios
    // ----------------
    task automatic resetValues;
        wb(1'b0, IDX_CLK_CFG, 8'h00);
        check(rd, 8'h50, "config default");
        wb(1'b0, IDX_TACH_A, 8'h00);
        check(rd, 8'h00, "result default");
        wb(1'b1, 8'h60, 8'ha5);
        wb(1'b0, 8'h60, 8'h00);
        check(rd, 8'h00, "unmapped read");
    endtask

    task automatic tachDivisors;
        int expCount;
        halfA <= 16'(HALF);
        halfB <= 16'(HALF);
        for (int c = 0; c < 4; c++)
        begin
            // preload plus prescaled ticks in one tach period
            expCount = 16 + 2 * HALF / (TICK << c);
            wb(1'b1, IDX_CLK_CFG, {2'(c), 2'(c), 4'h0});
            wb(1'b1, IDX_PRE_A, 8'h10);
            wb(1'b1, IDX_PRE_B, 8'h10);
            repeat (8 * HALF) @(posedge mclk);
            wb(1'b0, IDX_TACH_A, 8'h00);
            near({8'h00, rd}, expCount, 1, "a count");
            wb(1'b0, IDX_TACH_B, 8'h00);
            near({8'h00, rd}, expCount, 1, "b count");
        end
    endtask

    task automatic saturateReadOnly;
        wb(1'b1, IDX_CLK_CFG, 8'h00);
        wb(1'b1, IDX_PRE_A, 8'hf0);
        wb(1'b0, IDX_PRE_A, 8'h00);
        check(rd, 8'hf0, "preload readback");
        repeat (8 * HALF) @(posedge mclk);
        wb(1'b0, IDX_TACH_A, 8'h00);
        check(rd, 8'hff, "saturated count");
        wb(1'b1, IDX_TACH_A, 8'h00);
        wb(1'b0, IDX_TACH_A, 8'h00);
        check(rd, 8'hff, "result after write");
    endtask

    task automatic driveHold;
        pickB = 1'b0;
        wb(1'b1, IDX_FAN_A, 8'h01);
        holdLevel(1'b1);
        wb(1'b1, IDX_FAN_A, 8'h00);
        holdLevel(1'b0);
    endtask

    // duty 60 leaves four low steps; low time gives the step rate
    task automatic pwmCase(input logic b, input logic [3:0] cfg,
                           input logic clk, input int expLow);
        pickB = b;
        wb(1'b1, b ? IDX_FAN_B : IDX_FAN_A, {clk, 6'h3c, 1'b0});
        wb(1'b1, IDX_CLK_CFG, {4'h5, cfg});
        // finish any low phase begun at the old rate, then time a new one
        waitLevel(1'b1);
        waitLevel(1'b0);
        waitLevel(1'b1);
        near(16'(span), expLow, expLow / 16 + 4, "low time");
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        resetValues();
        tachDivisors();
        saturateReadOnly();
        driveHold();
        pwmCase(1'b0, 4'h0, 1'b0, 4 * int'(SPD_CYC_00));
        pwmCase(1'b0, 4'h4, 1'b0, 2 * int'(SPD_CYC_00));
        pwmCase(1'b1, 4'h8, 1'b1, 2 * int'(SPD_CYC_01));
        pwmCase(1'b1, 4'ha, 1'b0, 2 * int'(SPD_CYC_10));
        wrap_up();
    end

    // watchdog against a hang; the tests take about 50k cycles
    initial
    begin
        repeat (90000) @(posedge mclk);
        fail("watchdog expired");
        wrap_up();
    end
endmodule // fan_clock_and_tach_count_test
`default_nettype wire
